//--- rtl/bbbus_pkg.sv
package bbbus_pkg;

    localparam int DATA_W = 8;
    localparam int ADDR_W = 16;
    localparam int EXT_W = 8;

    // timing of one machine cycle, in ns as specified, then in clock cycles
    localparam int CLK_PERIOD_PS = 4000;
    localparam int SYNC_NS = 20;
    localparam int SETUP_NS = 20;
    localparam int STROBE_NS = 100;
    localparam int RELEASE_NS = 20;

    function automatic int ns_to_cyc(input int ns);
        int c;
        c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int SYNC_CYC = ns_to_cyc(SYNC_NS);
    localparam int SETUP_CYC = ns_to_cyc(SETUP_NS);
    localparam int STROBE_CYC = ns_to_cyc(STROBE_NS);
    localparam int RELEASE_CYC = ns_to_cyc(RELEASE_NS);
    localparam int CNT_W = 8;

    // cycle kinds
    typedef enum logic [1:0] {
        BBBUS_READ = 2'h0,
        BBBUS_WRITE = 2'h1,
        BBBUS_REFRESH = 2'h2,
        BBBUS_IRQ_ACK = 2'h3
    } bbbus_kind_t;

    // gray along idle, sync, setup, strobe, release
    typedef enum logic [2:0] {
        BBBUS_IDLE = 3'h0,
        BBBUS_SYNC = 3'h1,
        BBBUS_SETUP = 3'h3,
        BBBUS_STROBE = 3'h2,
        BBBUS_RELEASE = 3'h6,
        BBBUS_FLOAT = 3'h4
    } bbbus_state_t;

    typedef struct packed {
        bbbus_kind_t kind;
        logic is_io;
        logic fetch;
        logic expand;
        logic [EXT_W-1:0] ext_addr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } bbbus_req_t;

endpackage

//--- rtl/bbbus_sync.sv
`timescale 1ns/1ps
module bbbus_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // level from another domain
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1_ff;

    // stage1_ff feeds only the second stage
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            stage1_ff <= RESET_VAL;
            sync_out <= RESET_VAL;
        end else begin
            stage1_ff <= async_in;
            sync_out <= stage1_ff;
        end
    end

endmodule

//--- rtl/bbbus_master.sv
`timescale 1ns/1ps
// Function
// - master sets data direction from strobes, acknowledge
// - data drivers float whenever bus unused
// - float data bus while bus request asserted; here only between machine cycles
// - drive address; float it under bus request; here only between machine cycles
// - memory or I/O request marks address space
// - sync pulse frames extended address on data
// - drive both strobes, requests, expansion lines
// - write strobe marks valid data on bus
// - special cycles are not ordinary data accesses
// - refresh line triggers dynamic memory refresh
// - one sync pulse starts each machine cycle
// - status 1 marks instruction fetch cycles
// - status 0 gives extra processor timing; here status0_n_out carries the write direction instead
// - direction indicator high read, low write
// - selects stable before read or write strobe
module bbbus_master (
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // user request
    input wire logic req_valid_in,
    input wire bbbus_pkg::bbbus_req_t req_in,
    output logic req_ready_out,
    output logic done_out,
    output logic [bbbus_pkg::DATA_W-1:0] rdata_out,
    output logic bus_granted_out,
    output logic supply_fail_out,
    // backplane data bus
    input wire logic [bbbus_pkg::DATA_W-1:0] data_in,
    output logic [bbbus_pkg::DATA_W-1:0] data_out,
    output logic data_oe_out,
    // backplane address bus
    output logic [bbbus_pkg::ADDR_W-1:0] addr_out,
    output logic addr_oe_out,
    // backplane control lines, shared enable
    output logic ctl_oe_out,
    output logic wr_n_out,
    output logic rd_n_out,
    output logic io_select_n_out,
    output logic mem_select_n_out,
    output logic io_space_expand_out,
    output logic mem_space_expand_out,
    output logic refresh_n_out,
    output logic cycle_sync_n_out,
    output logic fetch_cycle_n_out,
    output logic status0_n_out,
    output logic irq_ack_n_out,
    // backplane inputs
    input wire logic bus_request_n_in,
    input wire logic supply_fail_n_in
);

    localparam logic [bbbus_pkg::CNT_W-1:0] SYNC_LD = bbbus_pkg::CNT_W'(bbbus_pkg::SYNC_CYC - 1);
    localparam logic [bbbus_pkg::CNT_W-1:0] SETUP_LD = bbbus_pkg::CNT_W'(bbbus_pkg::SETUP_CYC - 1);
    localparam logic [bbbus_pkg::CNT_W-1:0] STROBE_LD = bbbus_pkg::CNT_W'(bbbus_pkg::STROBE_CYC - 1);
    localparam logic [bbbus_pkg::CNT_W-1:0] RELEASE_LD = bbbus_pkg::CNT_W'(bbbus_pkg::RELEASE_CYC - 1);

    logic bus_request_n_s;
    logic supply_fail_n_s;
    logic [bbbus_pkg::DATA_W-1:0] data_s;

    bbbus_sync #(.WIDTH(2), .RESET_VAL(2'h3)) u_ctl_sync (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .async_in({bus_request_n_in, supply_fail_n_in}),
        .sync_out({bus_request_n_s, supply_fail_n_s})
    );

    // read data is held stable for the whole strobe, so a plain per-bit sync is safe
    bbbus_sync #(.WIDTH(bbbus_pkg::DATA_W), .RESET_VAL(8'h00)) u_data_sync (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .async_in(data_in),
        .sync_out(data_s)
    );

    bbbus_pkg::bbbus_state_t state_ff, nxt_state;
    logic [bbbus_pkg::CNT_W-1:0] cnt_ff, nxt_cnt;
    bbbus_pkg::bbbus_req_t req_ff, nxt_req;
    logic accept;
    logic cnt_zero;
    logic in_cycle;
    logic is_rd, is_wr, is_ref, is_ack;

    assign accept = req_valid_in && req_ready_out;
    assign cnt_zero = (cnt_ff == '0);

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_zero ? cnt_ff : cnt_ff - 1'b1;
        nxt_req = accept ? req_in : req_ff;
        case (state_ff)
            bbbus_pkg::BBBUS_IDLE: begin
                // bus request is honoured only between machine cycles
                if (accept) begin
                    nxt_state = bbbus_pkg::BBBUS_SYNC;
                    nxt_cnt = SYNC_LD;
                end else if (!bus_request_n_s) begin
                    nxt_state = bbbus_pkg::BBBUS_FLOAT;
                end
            end
            bbbus_pkg::BBBUS_SYNC: begin
                if (cnt_zero) begin
                    nxt_state = bbbus_pkg::BBBUS_SETUP;
                    nxt_cnt = SETUP_LD;
                end
            end
            bbbus_pkg::BBBUS_SETUP: begin
                if (cnt_zero) begin
                    nxt_state = bbbus_pkg::BBBUS_STROBE;
                    nxt_cnt = STROBE_LD;
                end
            end
            bbbus_pkg::BBBUS_STROBE: begin
                if (cnt_zero) begin
                    nxt_state = bbbus_pkg::BBBUS_RELEASE;
                    nxt_cnt = RELEASE_LD;
                end
            end
            bbbus_pkg::BBBUS_RELEASE: begin
                if (cnt_zero) begin
                    nxt_state = bbbus_pkg::BBBUS_IDLE;
                end
            end
            bbbus_pkg::BBBUS_FLOAT: begin
                if (bus_request_n_s) begin
                    nxt_state = bbbus_pkg::BBBUS_IDLE;
                end
            end
            default: begin
                nxt_state = bbbus_pkg::BBBUS_IDLE;
            end
        endcase
    end

    assign in_cycle = (nxt_state != bbbus_pkg::BBBUS_IDLE) && (nxt_state != bbbus_pkg::BBBUS_FLOAT);
    assign is_rd = (nxt_req.kind == bbbus_pkg::BBBUS_READ);
    assign is_wr = (nxt_req.kind == bbbus_pkg::BBBUS_WRITE);
    assign is_ref = (nxt_req.kind == bbbus_pkg::BBBUS_REFRESH);
    assign is_ack = (nxt_req.kind == bbbus_pkg::BBBUS_IRQ_ACK);

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            state_ff <= bbbus_pkg::BBBUS_IDLE;
            cnt_ff <= '0;
            req_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            req_ff <= nxt_req;
        end
    end

    // user side handshake and status
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            req_ready_out <= 1'b0;
            done_out <= 1'b0;
            bus_granted_out <= 1'b0;
            supply_fail_out <= 1'b0;
        end else begin
            // new cycles are refused while the logic supply is low
            req_ready_out <= (nxt_state == bbbus_pkg::BBBUS_IDLE) && supply_fail_n_s;
            done_out <= (state_ff == bbbus_pkg::BBBUS_RELEASE) && (nxt_state == bbbus_pkg::BBBUS_IDLE);
            bus_granted_out <= (nxt_state == bbbus_pkg::BBBUS_FLOAT);
            supply_fail_out <= !supply_fail_n_s;
        end
    end

    // read and acknowledge data: the synced copy lags the pins by two edges, so it is
    // taken on the last strobe cycle while the slave still drives
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            rdata_out <= '0;
        end else if (state_ff == bbbus_pkg::BBBUS_STROBE && cnt_zero &&
                     (req_ff.kind == bbbus_pkg::BBBUS_READ || req_ff.kind == bbbus_pkg::BBBUS_IRQ_ACK)) begin
            rdata_out <= data_s;
        end
    end

    // data bus: extended address during sync, write data afterwards, else floating
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            data_out <= '0;
            data_oe_out <= 1'b0;
        end else if (nxt_state == bbbus_pkg::BBBUS_SYNC) begin
            data_out <= nxt_req.ext_addr;
            data_oe_out <= 1'b1;
        end else if (in_cycle && is_wr) begin
            data_out <= nxt_req.wdata;
            data_oe_out <= 1'b1;
        end else begin
            data_out <= '0;
            data_oe_out <= 1'b0;
        end
    end

    // address and control are owned between cycles, released only to a temporary master
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            addr_out <= '0;
            addr_oe_out <= 1'b0;
            ctl_oe_out <= 1'b0;
        end else begin
            addr_out <= in_cycle ? nxt_req.addr : '0;
            addr_oe_out <= (nxt_state != bbbus_pkg::BBBUS_FLOAT);
            ctl_oe_out <= (nxt_state != bbbus_pkg::BBBUS_FLOAT);
        end
    end

    // selects span sync to release so the strobe sits inside them
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            io_select_n_out <= 1'b1;
            mem_select_n_out <= 1'b1;
            io_space_expand_out <= 1'b0;
            mem_space_expand_out <= 1'b0;
        end else begin
            // acknowledge always uses the I/O request line, whatever is_io says
            io_select_n_out <= !(in_cycle && (nxt_req.is_io || is_ack) && !is_ref);
            mem_select_n_out <= !(in_cycle && !nxt_req.is_io && !is_ack && !is_ref);
            io_space_expand_out <= in_cycle && nxt_req.is_io && nxt_req.expand;
            mem_space_expand_out <= in_cycle && !nxt_req.is_io && nxt_req.expand;
        end
    end

    // read, write and acknowledge strobes only in the strobe phase; refresh in setup and strobe
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            wr_n_out <= 1'b1;
            rd_n_out <= 1'b1;
            irq_ack_n_out <= 1'b1;
            refresh_n_out <= 1'b1;
        end else begin
            wr_n_out <= !(nxt_state == bbbus_pkg::BBBUS_STROBE && is_wr);
            rd_n_out <= !(nxt_state == bbbus_pkg::BBBUS_STROBE && is_rd);
            irq_ack_n_out <= !(nxt_state == bbbus_pkg::BBBUS_STROBE && is_ack);
            refresh_n_out <= !((nxt_state == bbbus_pkg::BBBUS_SETUP ||
                                nxt_state == bbbus_pkg::BBBUS_STROBE) && is_ref);
        end
    end

    // peripheral timing lines
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            cycle_sync_n_out <= 1'b1;
            fetch_cycle_n_out <= 1'b1;
            status0_n_out <= 1'b1;
        end else begin
            cycle_sync_n_out <= !(nxt_state == bbbus_pkg::BBBUS_SYNC);
            fetch_cycle_n_out <= !(in_cycle && ((is_rd && nxt_req.fetch) || is_ack));
            // carries read/write direction: high read, low write
            status0_n_out <= !(in_cycle && is_wr);
        end
    end

endmodule

//--- verif/bbbus_master_monitor.sv
`timescale 1ns/1ps
module bbbus_master_monitor (
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_n_in,
    // observed outputs
    input wire logic done_out,
    input wire logic bus_granted_out,
    input wire logic data_oe_out,
    input wire logic addr_oe_out,
    input wire logic [bbbus_pkg::ADDR_W-1:0] addr_out,
    input wire logic wr_n_out,
    input wire logic rd_n_out,
    input wire logic io_select_n_out,
    input wire logic mem_select_n_out,
    input wire logic refresh_n_out,
    input wire logic cycle_sync_n_out,
    input wire logic fetch_cycle_n_out,
    input wire logic status0_n_out,
    input wire logic irq_ack_n_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);

    grant_floats_a: assert property (bus_granted_out |-> !data_oe_out && !addr_oe_out)
        else $error("bus driven while granted");
    read_floats_a: assert property (!rd_n_out |-> !data_oe_out)
        else $error("data driven during read");
    write_drives_a: assert property (!wr_n_out |-> data_oe_out && !status0_n_out)
        else $error("write without data or indicator");
    space_excl_a: assert property (!mem_select_n_out |-> io_select_n_out)
        else $error("both selects low");
    select_first_a: assert property (($fell(rd_n_out) || $fell(wr_n_out)) |->
        $stable(addr_out) && ($past(mem_select_n_out && io_select_n_out) == 1'b0))
        else $error("strobe before selects");
    sync_pulse_a: assert property ($fell(cycle_sync_n_out) |=> !cycle_sync_n_out [*4] ##1 cycle_sync_n_out)
        else $error("sync pulse width");
    ext_on_sync_a: assert property (!cycle_sync_n_out |-> data_oe_out)
        else $error("no extension during sync");
    cycle_len_a: assert property ($fell(cycle_sync_n_out) |-> ##40 done_out)
        else $error("cycle length");
    ack_cycle_a: assert property (!irq_ack_n_out |-> !io_select_n_out && !fetch_cycle_n_out && rd_n_out)
        else $error("acknowledge cycle form");
    refresh_alone_a: assert property (!refresh_n_out |-> mem_select_n_out && io_select_n_out)
        else $error("refresh with select");
endmodule

bind bbbus_master bbbus_master_monitor u_bbbus_master_monitor (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .done_out(done_out),
    .bus_granted_out(bus_granted_out),
    .data_oe_out(data_oe_out),
    .addr_oe_out(addr_oe_out),
    .addr_out(addr_out),
    .wr_n_out(wr_n_out),
    .rd_n_out(rd_n_out),
    .io_select_n_out(io_select_n_out),
    .mem_select_n_out(mem_select_n_out),
    .refresh_n_out(refresh_n_out),
    .cycle_sync_n_out(cycle_sync_n_out),
    .fetch_cycle_n_out(fetch_cycle_n_out),
    .status0_n_out(status0_n_out),
    .irq_ack_n_out(irq_ack_n_out)
);

//--- verif/bbbus_slave_model.sv
`timescale 1ns/1ps
module bbbus_slave_model #(
    parameter logic [7:0] VECTOR = 8'h5a
) (
    // clock and line level
    input wire logic clk_in,
    input wire logic [7:0] bus_in,
    // master control group
    input wire logic [15:0] addr_in,
    input wire logic rd_n_in,
    input wire logic wr_n_in,
    input wire logic io_sel_n_in,
    input wire logic mem_sel_n_in,
    input wire logic io_exp_in,
    input wire logic mem_exp_in,
    input wire logic ack_n_in,
    input wire logic sync_n_in,
    // slave drive
    output logic drv_out,
    output logic [7:0] dat_out,
    output logic [7:0] ext_out
);
    logic [7:0] mem_ff [256];
    logic [7:0] io_ff [256];
    logic [7:0] ext_ff;
    logic sel_mem;
    logic sel_io;
    assign sel_mem = !mem_sel_n_in && !mem_exp_in;
    // an acknowledge cycle is not an ordinary port access
    assign sel_io = !io_sel_n_in && !io_exp_in && ack_n_in;
    assign drv_out = (!rd_n_in && (sel_mem || sel_io)) || !ack_n_in;
    assign dat_out = !ack_n_in ? VECTOR : sel_io ? io_ff[addr_in[7:0]] : mem_ff[addr_in[7:0]];
    assign ext_out = ext_ff;
    always_ff @(posedge clk_in) begin
        if (!wr_n_in && sel_mem) begin
            mem_ff[addr_in[7:0]] <= bus_in;
        end
        if (!wr_n_in && sel_io) begin
            io_ff[addr_in[7:0]] <= bus_in;
        end
    end
    always_ff @(posedge clk_in) begin
        if (!sync_n_in) begin
            ext_ff <= bus_in;
        end
    end
endmodule

//--- verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic req_valid_in = 1'b0;
    bbbus_pkg::bbbus_req_t req_in = '0;
    logic bus_request_n_in = 1'b1;
    logic supply_fail_n_in = 1'b1;
    logic req_ready_out, done_out, bus_granted_out, supply_fail_out, data_oe_out, addr_oe_out, ctl_oe_out;
    logic wr_n_out, rd_n_out, io_select_n_out, mem_select_n_out, cycle_sync_n_out, irq_ack_n_out;
    logic io_x, mem_x, drv;
    logic [7:0] rdata_out, data_out, data_in, sdat, ext, last_ff;
    logic [15:0] addr_out;
    int n_errors = 0;
    int checked = 0;
    // a released line shows the inverse of its last level, never a held value
    assign data_in = data_oe_out ? data_out : drv ? sdat : ~last_ff;
    always_ff @(posedge clk_in) last_ff <= data_in;
    initial forever #2 clk_in = ~clk_in;

    bbbus_master u_bbbus_master (.clk_in, .reset_n_in, .req_valid_in, .req_in, .req_ready_out, .done_out,
        .rdata_out, .bus_granted_out, .supply_fail_out, .data_in, .data_out, .data_oe_out, .addr_out,
        .addr_oe_out, .ctl_oe_out, .wr_n_out, .rd_n_out, .io_select_n_out, .mem_select_n_out,
        .io_space_expand_out(io_x), .mem_space_expand_out(mem_x), .refresh_n_out(), .cycle_sync_n_out,
        .fetch_cycle_n_out(), .status0_n_out(), .irq_ack_n_out, .bus_request_n_in, .supply_fail_n_in);
    bbbus_slave_model u_bbbus_slave_model (.clk_in, .bus_in(data_in), .addr_in(addr_out),
        .rd_n_in(rd_n_out), .wr_n_in(wr_n_out), .io_sel_n_in(io_select_n_out), .mem_sel_n_in(mem_select_n_out),
        .io_exp_in(io_x), .mem_exp_in(mem_x), .ack_n_in(irq_ack_n_out), .sync_n_in(cycle_sync_n_out),
        .drv_out(drv), .dat_out(sdat), .ext_out(ext));

    task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk1(input string nm, input logic e, input logic g);
        chk8(nm, {7'h0, e}, {7'h0, g});
    endtask
    task automatic op(input bbbus_pkg::bbbus_kind_t k, input logic io, input logic x, input logic [7:0] w);
        int n;
        @(posedge clk_in);
        for (n = 0; n < 100 && req_ready_out !== 1'b1; n++) @(posedge clk_in);
        req_valid_in <= 1'b1;
        req_in <= '{k, io, 1'b1, x, 8'h3c, 16'h1234, w};
        @(posedge clk_in);
        req_valid_in <= 1'b0;
        for (n = 0; n < 60 && done_out !== 1'b1; n++) @(posedge clk_in);
        chk1("done", 1'b1, done_out);
    endtask

    task automatic t_mem;
        op(bbbus_pkg::BBBUS_WRITE, 1'b0, 1'b0, 8'ha5);
        chk8("ext", 8'h3c, ext);
        op(bbbus_pkg::BBBUS_WRITE, 1'b0, 1'b1, 8'h00);
        op(bbbus_pkg::BBBUS_READ, 1'b0, 1'b0, 8'h00);
        chk8("mem", 8'ha5, rdata_out);
        $display("test mem done");
    endtask
    task automatic t_io;
        op(bbbus_pkg::BBBUS_WRITE, 1'b1, 1'b0, 8'h66);
        op(bbbus_pkg::BBBUS_WRITE, 1'b1, 1'b1, 8'h99);
        op(bbbus_pkg::BBBUS_READ, 1'b1, 1'b0, 8'h00);
        chk8("io", 8'h66, rdata_out);
        op(bbbus_pkg::BBBUS_IRQ_ACK, 1'b1, 1'b0, 8'h00);
        chk8("vector", 8'h5a, rdata_out);
        op(bbbus_pkg::BBBUS_REFRESH, 1'b0, 1'b0, 8'h00);
        op(bbbus_pkg::BBBUS_READ, 1'b0, 1'b0, 8'h00);
        chk8("mem kept", 8'ha5, rdata_out);
        $display("test io done");
    endtask
    task automatic t_busreq;
        @(posedge clk_in);
        bus_request_n_in <= 1'b0;
        repeat (5) @(posedge clk_in);
        chk1("granted", 1'b1, bus_granted_out);
        chk1("data oe", 1'b0, data_oe_out);
        chk1("addr oe", 1'b0, addr_oe_out);
        chk1("ctl oe", 1'b0, ctl_oe_out);
        chk1("ready", 1'b0, req_ready_out);
        bus_request_n_in <= 1'b1;
        repeat (5) @(posedge clk_in);
        chk1("regained", 1'b1, addr_oe_out);
        chk1("ctl regained", 1'b1, ctl_oe_out);
        $display("test bus request done");
    endtask
    task automatic t_supply;
        supply_fail_n_in <= 1'b0;
        repeat (5) @(posedge clk_in);
        chk1("supply", 1'b1, supply_fail_out);
        chk1("blocked", 1'b0, req_ready_out);
        supply_fail_n_in <= 1'b1;
        repeat (5) @(posedge clk_in);
        chk1("resumed", 1'b1, req_ready_out);
        chk1("idle float", 1'b0, data_oe_out);
        $display("test supply done");
    endtask

    task automatic end_of_test;
        $display("checked %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (8) @(posedge clk_in);
        reset_n_in <= 1'b1;
        t_mem();
        t_io();
        t_busreq();
        t_supply();
        end_of_test();
    end
    initial begin
        repeat (20000) @(posedge clk_in);
        n_errors++;
        end_of_test();
    end
endmodule
